// ===== include/tgj_pkg.sv
`default_nettype none
package tgj_pkg;
  // Data path width of counter and data register
  localparam int unsigned CNT_W = 16;
  // Register byte offsets on the plain register port
  localparam logic [7:0] OFS_MODE_CFG = 8'h00;
  localparam logic [7:0] OFS_EDGE_CFG = 8'h04;
  localparam logic [7:0] OFS_DATA_VAL = 8'h08;
  localparam logic [7:0] OFS_COUNTER  = 8'h0c;
  localparam logic [7:0] OFS_START    = 8'h10;
  localparam logic [7:0] OFS_STOP     = 8'h14;
  localparam logic [7:0] OFS_ENABLE   = 8'h18;
  // Mode config, edge config and trigger field positions
  localparam int unsigned POS_CKS   = 14;
  localparam int unsigned POS_CCS   = 12;
  localparam int unsigned POS_MAS   = 11;
  localparam int unsigned POS_STS   = 8;
  localparam int unsigned POS_COS   = 6;
  localparam int unsigned POS_MD    = 1;
  localparam int unsigned POS_MD0   = 0;
  localparam int unsigned POS_TIS   = 0;
  localparam int unsigned POS_TRIG  = 0;
  // Function mode codes
  localparam logic [3:0] MD_JUDGE = 4'h1;
  localparam logic [3:0] MD_GATE  = 4'hc;
  // Input edge select codes
  localparam logic [1:0] TIS_FALL = 2'h0;
  localparam logic [1:0] TIS_RISE = 2'h1;
  // Reset and special counter values
  localparam logic [15:0] RST_MODE_CFG = 16'h0000;
  localparam logic [1:0]  RST_EDGE_CFG = 2'h0;
  localparam logic [15:0] RST_DATA_VAL = 16'h0000;
  localparam logic [15:0] RST_COUNTER  = 16'h0000;
  localparam logic [15:0] CNT_ZERO     = 16'h0000;
  localparam logic [15:0] CNT_WRAP     = 16'hffff;
  // Prescaler counter width and divide exponents for the four operation clocks
  localparam int unsigned PRE_W    = 8;
  localparam int unsigned PRE_EXP0 = 0;
  localparam int unsigned PRE_EXP1 = 2;
  localparam int unsigned PRE_EXP2 = 4;
  localparam int unsigned PRE_EXP3 = 6;

  // Channel activity states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_RUN  = 3'b100
  } tgj_state_type;
endpackage
`default_nettype wire

// ===== include/tgj_tick_if.sv
`timescale 1ns/1ps
`default_nettype none
// Carries the four prescaled operation clock enables
interface tgj_tick_if;
  logic [3:0] tick;
  modport src (output tick);
  modport snk (input tick);
endinterface
`default_nettype wire

// ===== core/tgj_prescaler.sv
`timescale 1ns/1ps
`default_nettype none
module tgj_prescaler #(
  parameter int unsigned W    = tgj_pkg::PRE_W,
  parameter int unsigned EXP0 = tgj_pkg::PRE_EXP0,
  parameter int unsigned EXP1 = tgj_pkg::PRE_EXP1,
  parameter int unsigned EXP2 = tgj_pkg::PRE_EXP2,
  parameter int unsigned EXP3 = tgj_pkg::PRE_EXP3
) (
  input  wire logic   sys_clk,
  input  wire logic   nrst,
  tgj_tick_if.src     ticks
);
  localparam int unsigned EXPS [4] = '{EXP0, EXP1, EXP2, EXP3};

  // Exponents beyond the counter width cannot be served
  if (EXP0 > W || EXP1 > W || EXP2 > W || EXP3 > W) begin : g_chk
    $error("prescaler exponent exceeds counter width");
  end

  // Low-bit mask for one divide exponent
  function automatic logic [W-1:0] low_mask(input int unsigned e);
    logic [W-1:0] m;
    m = '0;
    for (int unsigned i = 0; i < W; i++) begin
      if (i < e) begin
        m[i] = 1'b1;
      end
    end
    return m;
  endfunction

  logic [W-1:0] pre_r;

  // Free-running divider shared by all four clocks
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      pre_r <= '0;
    end else begin
      pre_r <= pre_r + {{(W-1){1'b0}}, 1'b1};
    end
  end

  // One-cycle enable each 2**exp cycles
  for (genvar k = 0; k < 4; k++) begin : g_tick
    assign ticks.tick[k] = (pre_r & low_mask(EXPS[k])) == low_mask(EXPS[k]);
  end
endmodule
`default_nettype wire

// ===== core/tgj_top.sv
`timescale 1ns/1ps
`default_nettype none
module tgj_top #(
  parameter int unsigned CNT_W = tgj_pkg::CNT_W
) (
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  input  wire logic [7:0]  bus_addr,
  input  wire logic [31:0] bus_wdata,
  input  wire logic        bus_wr,
  input  wire logic        bus_rd,
  output logic      [31:0] bus_rdata,
  input  wire logic        timer_input_pin,
  output logic             timer_output_pin,
  output logic             channel_interrupt,
  output logic             enable_status_bit
);

  // The register map keeps counter and data value in bits 15:0,
  // so no other counter width can be served
  if (CNT_W != 16) begin : g_width_chk
    $error("counter width must be 16");
  end

  ////////////////////////////////////////////////////////////////////
  // Edge decoding shared by the judge and gate paths

  // Valid edge for judge mode per edge select
  function automatic logic judge_edge(
    input logic [1:0] input_edge_select,
    input logic       rise,
    input logic       fall
  );
    logic v;
    v = 1'b0;
    case (input_edge_select)
      tgj_pkg::TIS_FALL: v = fall;
      tgj_pkg::TIS_RISE: v = rise;
      default:           v = rise | fall;
    endcase
    return v;
  endfunction

  // Start edge for gate mode; the stop edge is the reverse one
  function automatic logic gate_start(
    input logic [1:0] input_edge_select,
    input logic       rise,
    input logic       fall
  );
    return input_edge_select[0] ? rise : fall;
  endfunction

  // One count-down step; at zero the given reload value is taken instead
  function automatic logic [15:0] count_step(
    input logic [15:0] cnt,
    input logic [15:0] reload
  );
    logic [15:0] n;
    n = cnt - 16'h0001;
    if (cnt == tgj_pkg::CNT_ZERO) begin
      n = reload;
    end
    return n;
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Registers

  logic [15:0]          mode_cfg_r;
  logic [1:0]           edge_cfg_r;
  logic [15:0]          data_val_r;
  logic [15:0]          cnt_r;
  logic [15:0]          cnt_nxt;
  logic                 tin_d_r;
  logic                 irq_r;
  logic                 irq_nxt;
  logic                 gate_fresh_r;
  logic [31:0]          rdata_r;
  tgj_pkg::tgj_state_type state_r;
  tgj_pkg::tgj_state_type state_nxt;

  // Decoded bus strobes
  logic wr_mode;
  logic wr_edge;
  logic wr_data;
  logic start_wr;
  logic stop_wr;

  assign wr_mode  = bus_wr && bus_addr == tgj_pkg::OFS_MODE_CFG;
  assign wr_edge  = bus_wr && bus_addr == tgj_pkg::OFS_EDGE_CFG;
  assign wr_data  = bus_wr && bus_addr == tgj_pkg::OFS_DATA_VAL;
  // Trigger bits are never stored, so they always read back zero
  assign start_wr = bus_wr && bus_addr == tgj_pkg::OFS_START
                    && bus_wdata[tgj_pkg::POS_TRIG];
  assign stop_wr  = bus_wr && bus_addr == tgj_pkg::OFS_STOP
                    && bus_wdata[tgj_pkg::POS_TRIG];

  // Configuration fields
  logic [1:0] prescaler_select;
  logic       ccs;
  logic [3:0] md;
  logic       md0;

  assign prescaler_select = mode_cfg_r[tgj_pkg::POS_CKS +: 2];
  assign ccs = mode_cfg_r[tgj_pkg::POS_CCS];
  assign md  = mode_cfg_r[tgj_pkg::POS_MD +: 4];
  assign md0 = mode_cfg_r[tgj_pkg::POS_MD0];

  // Mode config register
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      mode_cfg_r <= tgj_pkg::RST_MODE_CFG;
    end else if (wr_mode) begin
      mode_cfg_r <= bus_wdata[15:0];
    end
  end

  // Edge config register, only the edge select bits exist
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      edge_cfg_r <= tgj_pkg::RST_EDGE_CFG;
    end else if (wr_edge) begin
      edge_cfg_r <= bus_wdata[tgj_pkg::POS_TIS +: 2];
    end
  end

  // Data value; the counter only samples it at a load
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      data_val_r <= tgj_pkg::RST_DATA_VAL;
    end else if (wr_data) begin
      data_val_r <= bus_wdata[15:0];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Count clock selection

  tgj_tick_if ticks_if ();

  tgj_prescaler u_pre (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .ticks   (ticks_if)
  );

  // Count source 1 (input edges) is not served, so no ticks then
  logic tick;
  assign tick = ticks_if.tick[prescaler_select] && !ccs;

  ////////////////////////////////////////////////////////////////////
  // Input edge detection

  // Pin is taken as synchronous, one stage keeps the last level
  // After reset a high pin looks like a rise; harmless, since the
  // channel is stopped then and ignores every edge
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      tin_d_r <= 1'b0;
    end else begin
      tin_d_r <= timer_input_pin;
    end
  end

  logic rise;
  logic fall;
  logic j_edge;
  logic g_start;
  logic g_stop;

  assign rise    = timer_input_pin && !tin_d_r;
  assign fall    = !timer_input_pin && tin_d_r;
  assign j_edge  = judge_edge(edge_cfg_r, rise, fall);
  assign g_start = gate_start(edge_cfg_r, rise, fall);
  assign g_stop  = gate_start(edge_cfg_r, fall, rise);

  // Tells a fresh gate start, which loads the data value at its first
  // start edge, from a resume after a stop edge, which keeps the count
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      gate_fresh_r <= 1'b1;
    end else if (state_r == tgj_pkg::ST_IDLE) begin
      gate_fresh_r <= 1'b1;
    end else if (state_r == tgj_pkg::ST_WAIT && g_start) begin
      gate_fresh_r <= 1'b0;
    end
  end

  // Judge condition: polarity 0 is less-or-equal, 1 is greater
  logic judge_hit;
  assign judge_hit = md0 ? (cnt_r > data_val_r)
                         : (cnt_r <= data_val_r);

  ////////////////////////////////////////////////////////////////////
  // Channel control

  // Next state, counter and interrupt for the active mode
  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    irq_nxt   = 1'b0;
    case (state_r)
      tgj_pkg::ST_IDLE: begin
        if (start_wr && md == tgj_pkg::MD_JUDGE) begin
          state_nxt = tgj_pkg::ST_RUN;
          cnt_nxt   = data_val_r;
        end else if (start_wr && md == tgj_pkg::MD_GATE) begin
          // The count keeps its value until the first start edge
          state_nxt = tgj_pkg::ST_WAIT;
        end
      end
      tgj_pkg::ST_WAIT: begin
        if (stop_wr) begin
          state_nxt = tgj_pkg::ST_IDLE;
        end else if (md == tgj_pkg::MD_GATE && g_start) begin
          // A fresh start loads the data value, a resume keeps the held count
          state_nxt = tgj_pkg::ST_RUN;
          if (gate_fresh_r) begin
            cnt_nxt = data_val_r;
          end
        end
      end
      tgj_pkg::ST_RUN: begin
        if (stop_wr) begin
          state_nxt = tgj_pkg::ST_IDLE;
        end else if (md == tgj_pkg::MD_JUDGE) begin
          if (j_edge || start_wr) begin
            irq_nxt = judge_hit;
            cnt_nxt = data_val_r;
          end else if (tick) begin
            cnt_nxt = count_step(cnt_r, tgj_pkg::CNT_WRAP);
          end
        end else if (md == tgj_pkg::MD_GATE) begin
          // Start writes here are ignored
          if (g_stop) begin
            state_nxt = tgj_pkg::ST_WAIT;
          end else if (tick) begin
            // Underflow raises the interrupt and reloads the data value
            irq_nxt = cnt_r == tgj_pkg::CNT_ZERO;
            cnt_nxt = count_step(cnt_r, data_val_r);
          end
        end
      end
      default: begin
        state_nxt = tgj_pkg::ST_IDLE;
      end
    endcase
  end

  // Channel state
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= tgj_pkg::ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Counter holds whenever the channel is stopped
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_r <= tgj_pkg::RST_COUNTER;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  // Interrupt is a one-cycle pulse from a flop
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= irq_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Status and pin outputs

  assign channel_interrupt = irq_r;
  assign enable_status_bit = state_r != tgj_pkg::ST_IDLE;
  // The output pin stays quiet; only direct output mode may use it
  assign timer_output_pin  = 1'b0;

  ////////////////////////////////////////////////////////////////////
  // Register read port

  // Read data for one address, unmapped reads give zero
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (bus_addr)
      tgj_pkg::OFS_MODE_CFG: rd_mux = {16'h0000, mode_cfg_r};
      tgj_pkg::OFS_EDGE_CFG: rd_mux = {30'h0, edge_cfg_r};
      tgj_pkg::OFS_DATA_VAL: rd_mux = {16'h0000, data_val_r};
      // Reading only samples the counter, never touches it
      tgj_pkg::OFS_COUNTER:  rd_mux = {16'h0000, cnt_r};
      tgj_pkg::OFS_ENABLE:   rd_mux = {31'h0, enable_status_bit};
      // Trigger bits have no storage behind them
      tgj_pkg::OFS_START:    rd_mux = 32'h0000_0000;
      tgj_pkg::OFS_STOP:     rd_mux = 32'h0000_0000;
      default:               rd_mux = 32'h0000_0000;
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rdata_r <= 32'h0000_0000;
    end else if (bus_rd) begin
      rdata_r <= rd_mux;
    end else begin
      rdata_r <= 32'h0000_0000;
    end
  end

  assign bus_rdata = rdata_r;

endmodule
`default_nettype wire

// ===== dv/tgj_top_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module tgj_top_asserts (
  input wire logic        sys_clk,
  input wire logic        nrst,
  input wire logic [7:0]  bus_addr,
  input wire logic [31:0] bus_wdata,
  input wire logic        bus_wr,
  input wire logic        bus_rd,
  input wire logic [31:0] bus_rdata,
  input wire logic        timer_input_pin,
  input wire logic        timer_output_pin,
  input wire logic        channel_interrupt,
  input wire logic        enable_status_bit
);
  logic [3:0] mode_r;
  logic       wr_start;
  logic       wr_stop;
  logic       ok_mode;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  // Shadow of the mode field, since a start in an unknown mode is ignored
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      mode_r <= 4'h0;
    end else if (bus_wr && bus_addr == tgj_pkg::OFS_MODE_CFG) begin
      mode_r <= bus_wdata[4:1];
    end
  end
  // Trigger writes decoded from the bus
  assign wr_start = bus_wr && bus_addr == tgj_pkg::OFS_START && bus_wdata[0];
  assign wr_stop  = bus_wr && bus_addr == tgj_pkg::OFS_STOP && bus_wdata[0];
  assign ok_mode  = mode_r == tgj_pkg::MD_JUDGE || mode_r == tgj_pkg::MD_GATE;
  //////////////////////////////
  a_out_pin_low: assert property (timer_output_pin == 1'b0)
    else $error("output pin driven");
  a_start_sets_en: assert property (wr_start && ok_mode |=> enable_status_bit)
    else $error("start did not enable");
  a_stop_clears: assert property (wr_stop |=> !enable_status_bit)
    else $error("stop did not disable");
  a_en_rise_cause: assert property ($rose(enable_status_bit) |-> $past(wr_start))
    else $error("enable rose without start");
  a_en_fall_cause: assert property ($fell(enable_status_bit) |-> $past(wr_stop))
    else $error("enable fell without stop");
  a_trig_reads_zero: assert property (bus_rd && (bus_addr == tgj_pkg::OFS_START ||
    bus_addr == tgj_pkg::OFS_STOP) |=> bus_rdata == 32'h0)
    else $error("trigger bit read nonzero");
  a_irq_when_en: assert property (channel_interrupt |-> $past(enable_status_bit))
    else $error("interrupt while disabled");
  a_data_readback: assert property (bus_wr && bus_addr == tgj_pkg::OFS_DATA_VAL ##1 !bus_wr
    ##1 bus_rd && bus_addr == tgj_pkg::OFS_DATA_VAL |=> bus_rdata[15:0] == $past(bus_wdata[15:0], 3))
    else $error("data value readback wrong");
  // Main scenarios reached
  c_irq: cover property (channel_interrupt);
  c_enable: cover property ($rose(enable_status_bit));
  c_cnt_read: cover property (bus_rd && bus_addr == tgj_pkg::OFS_COUNTER);
endmodule
bind tgj_top tgj_top_asserts u_tgj_top_asserts (.sys_clk, .nrst, .bus_addr, .bus_wdata, .bus_wr,
  .bus_rd, .bus_rdata, .timer_input_pin, .timer_output_pin, .channel_interrupt, .enable_status_bit);
`default_nettype wire

// ===== dv/tgj_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
module tgj_pin_model (
  input  wire logic nrst,
  input  wire logic lvl,
  output logic      pin
);
  // Level passes straight through so an edge lands in the cycle it is set; idles high in reset
  assign pin = nrst ? lvl : 1'b1;
endmodule
`default_nettype wire

// ===== dv/tgj_top_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tgj_top_tb_top;
  logic        sys_clk;
  logic        nrst;
  logic [7:0]  bus_addr;
  logic [31:0] bus_wdata;
  logic        bus_wr;
  logic        bus_rd;
  logic [31:0] bus_rdata;
  logic        pin_lvl;
  logic        pin;
  logic        out_pin;
  logic        irq;
  logic        en;
  logic [15:0] irq_cnt;
  logic [31:0] a;
  logic [31:0] b;
  int          err_count;
  int          num_checks;
  tgj_top u_tgj_top (.sys_clk, .nrst, .bus_addr, .bus_wdata, .bus_wr, .bus_rd, .bus_rdata,
    .timer_input_pin(pin), .timer_output_pin(out_pin), .channel_interrupt(irq), .enable_status_bit(en));
  tgj_pin_model u_tgj_pin_model (.nrst, .lvl(pin_lvl), .pin);
  //////////////////////////////
  // Clock at 50 MHz
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  // Interrupt pulses are counted so checks need not catch the exact cycle
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      irq_cnt <= 16'h0;
    end else if (irq === 1'b1) begin
      irq_cnt <= irq_cnt + 16'h1;
    end
  end
  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_flag(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic conclude;
    $display("checks=%0d errors=%0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  //////////////////////////////
  // Bus cycles: a write is taken at the edge where the task returns
  task automatic wr(input logic [7:0] ad, input logic [15:0] d);
    @(posedge sys_clk);
    bus_addr  <= ad;
    bus_wdata <= {16'h0, d};
    bus_wr    <= 1'b1;
    @(posedge sys_clk);
    bus_wr    <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] ad, output logic [31:0] q);
    @(posedge sys_clk);
    bus_addr <= ad;
    bus_rd   <= 1'b1;
    @(posedge sys_clk);
    bus_rd   <= 1'b0;
    @(posedge sys_clk);
    q = bus_rdata;
  endtask
  // Stop first, since setup is only legal while the channel is stopped
  task automatic cfg(input logic [15:0] m, input logic [1:0] t, input logic [15:0] d);
    wr(tgj_pkg::OFS_STOP, 16'h0001);
    // Simultaneous rewrite is absent here, so its settings stay cleared
    wr(tgj_pkg::OFS_MODE_CFG, m);
    wr(tgj_pkg::OFS_EDGE_CFG, {14'h0, t});
    wr(tgj_pkg::OFS_DATA_VAL, d);
  endtask
  //////////////////////////////
  task automatic t_reset;
    logic [7:0] ads [6];
    ads = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h18, 8'h1c};
    foreach (ads[i]) begin
      rd(ads[i], a);
      chk_val(a[15:0], 16'h0000);
    end
    wr(tgj_pkg::OFS_DATA_VAL, 16'h5a5a);
    rd(tgj_pkg::OFS_DATA_VAL, a);
    chk_val(a[15:0], 16'h5a5a);
    $display("test reset done");
  endtask
  // Ticks over 64 cycles give the divide ratio of each clock select
  task automatic t_prescale;
    for (logic [2:0] k = 0; k < 4; k++) begin
      cfg({k[1:0], 14'h0102}, tgj_pkg::TIS_RISE, 16'h0100);
      wr(tgj_pkg::OFS_START, 16'h0001);
      rd(tgj_pkg::OFS_COUNTER, a);
      repeat (61) @(posedge sys_clk);
      rd(tgj_pkg::OFS_COUNTER, b);
      chk_val(a[15:0] - b[15:0], 16'h0040 >> (2 * k));
    end
    $display("test prescale done");
  endtask
  task automatic t_wrap;
    cfg(16'h0102, tgj_pkg::TIS_RISE, 16'h0003);
    wr(tgj_pkg::OFS_START, 16'h0001);
    rd(tgj_pkg::OFS_COUNTER, a);
    chk_val(a[15:0], 16'h0002);
    rd(tgj_pkg::OFS_COUNTER, a);
    chk_val(a[15:0], 16'hffff);
    $display("test wrap done");
  endtask
  // Data shrinks mid-count, so only the greater-than polarity fires
  task automatic t_judge;
    logic [15:0] n0;
    for (logic [1:0] p = 0; p < 2; p++) begin
      cfg(16'h0102 | {15'h0, p[0]}, tgj_pkg::TIS_FALL, 16'h0010);
      pin_lvl <= 1'b1;
      n0 = irq_cnt;
      wr(tgj_pkg::OFS_START, 16'h0001);
      wr(tgj_pkg::OFS_DATA_VAL, 16'h0004);
      pin_lvl <= 1'b0;
      rd(tgj_pkg::OFS_COUNTER, a);
      chk_val(a[15:0], 16'h0004);
      chk_val(irq_cnt - n0, {14'h0, p});
    end
    $display("test judge done");
  endtask
  task automatic t_edges;
    logic [15:0] n0;
    for (logic [2:0] t = 0; t < 4; t++) begin
      cfg(16'h0102, t[1:0], 16'h0010);
      pin_lvl <= 1'b0;
      n0 = irq_cnt;
      wr(tgj_pkg::OFS_START, 16'h0001);
      repeat (2) @(posedge sys_clk);
      pin_lvl <= 1'b1;
      repeat (3) @(posedge sys_clk);
      pin_lvl <= 1'b0;
      repeat (3) @(posedge sys_clk);
      chk_val(irq_cnt - n0, t[1] ? 16'h2 : 16'h1);
    end
    $display("test edges done");
  endtask
  task automatic t_stop;
    rd(tgj_pkg::OFS_ENABLE, a);
    chk_val(a[15:0], 16'h0001);
    wr(tgj_pkg::OFS_STOP, 16'h0001);
    rd(tgj_pkg::OFS_COUNTER, a);
    rd(tgj_pkg::OFS_COUNTER, b);
    chk_val(b[15:0], a[15:0]);
    chk_flag(en, 1'b0);
    rd(tgj_pkg::OFS_START, a);
    chk_val(a[15:0], 16'h0000);
    rd(tgj_pkg::OFS_STOP, a);
    chk_val(a[15:0], 16'h0000);
    $display("test stop done");
  endtask
  // Low-width gate: falling edge starts from FFFF, rising edge stops
  task automatic t_gate_low;
    cfg(16'h0218, 2'h2, 16'hffff);
    pin_lvl <= 1'b1;
    wr(tgj_pkg::OFS_START, 16'h0001);
    pin_lvl <= 1'b0;
    repeat (5) @(posedge sys_clk);
    pin_lvl <= 1'b1;
    rd(tgj_pkg::OFS_COUNTER, a);
    chk_val(a[15:0], 16'hfffb);
    $display("test gate low done");
  endtask
  // Full wrap from FFFF takes about 65536 cycles at the fastest clock
  task automatic t_gate;
    logic [15:0] n0;
    logic [31:0] c;
    cfg(16'h0218, 2'h3, 16'hffff);
    pin_lvl <= 1'b0;
    wr(tgj_pkg::OFS_START, 16'h0001);
    // Enabled but waiting for the start edge, so the count must not move
    rd(tgj_pkg::OFS_COUNTER, a);
    rd(tgj_pkg::OFS_COUNTER, b);
    chk_val(b[15:0], a[15:0]);
    pin_lvl <= 1'b1;
    repeat (10) @(posedge sys_clk);
    pin_lvl <= 1'b0;
    rd(tgj_pkg::OFS_COUNTER, a);
    rd(tgj_pkg::OFS_COUNTER, b);
    chk_val(b[15:0], a[15:0]);
    // Loaded FFFF at the start edge, then nine ticks before the stop edge
    chk_val(a[15:0], 16'hfff6);
    pin_lvl <= 1'b1;
    wr(tgj_pkg::OFS_START, 16'h0001);
    rd(tgj_pkg::OFS_COUNTER, c);
    chk_flag(c[15:0] < a[15:0] && c[15:0] > a[15:0] - 16'h20, 1'b1);
    n0 = irq_cnt;
    for (int i = 0; i < 70000 && irq_cnt == n0; i++) @(posedge sys_clk);
    chk_val(irq_cnt - n0, 16'h1);
    rd(tgj_pkg::OFS_COUNTER, a);
    chk_flag(a[15:0] > 16'hff00, 1'b1);
    $display("test gate done");
  endtask
  //////////////////////////////
  // Reset for ten cycles, then the tests in order
  initial begin
    nrst      = 1'b0;
    bus_addr  = 8'h00;
    bus_wdata = 32'h0;
    bus_wr    = 1'b0;
    bus_rd    = 1'b0;
    pin_lvl   = 1'b1;
    repeat (10) @(posedge sys_clk);
    nrst <= 1'b1;
    t_reset;
    t_prescale;
    t_wrap;
    t_judge;
    t_edges;
    t_stop;
    t_gate_low;
    t_gate;
    conclude;
  end
  // Watchdog well beyond the long gate wrap
  initial begin
    repeat (80000) @(posedge sys_clk);
    err_count++;
    conclude;
  end
endmodule
`default_nettype wire
